// ---- clkcfg_defines.svh ----
// offsets, reset values, field positions and codes of the clock configuration block
`ifndef CLKCFG_DEFINES_SVH
`define CLKCFG_DEFINES_SVH
`define CLKCFG_IDX_RATE   8'h3B
`define CLKCFG_IDX_TRIM   8'h3C
`define CLKCFG_IDX_PLL    8'h3D
`define CLKCFG_IDX_PDIV   8'h3E
`define CLKCFG_IDX_STAT   8'h44
`define CLKCFG_IDX_ACT    8'h45
`define CLKCFG_RST_RATE   8'h7A
`define CLKCFG_RST_TRIM   8'h00
`define CLKCFG_RST_PLL    8'h00
`define CLKCFG_RST_PDIV   8'h08
`define CLKCFG_EXP_HI     7
`define CLKCFG_EXP_LO     5
`define CLKCFG_MAN_HI     4
`define CLKCFG_MAN_LO     0
`define CLKCFG_SEL_HI     7
`define CLKCFG_SEL_LO     4
`define CLKCFG_EN_BIT     3
`define CLKCFG_SLEEP_BIT  2
`define CLKCFG_FB_HI      1
`define CLKCFG_FB_LO      0
`define CLKCFG_MAN_OFS    13'h0021
`define CLKCFG_ONE        13'h0001
`define CLKCFG_FB_23      5'h17
`define CLKCFG_FB_27      5'h1B
`define CLKCFG_FB_28      5'h1C
`define CLKCFG_FB_CODE27  2'h1
`define CLKCFG_FB_CODE28  2'h2
`define CLKCFG_SEL_GPIO   4'h0
`define CLKCFG_SEL_PLL    4'h1
`define CLKCFG_SEL_LOW    4'h2
`define CLKCFG_SEL_HIGH   4'h3
`define CLKCFG_SEL_XTAL1  4'h4
`define CLKCFG_SEL_XTAL2  4'h5
`define CLKCFG_SEL_XTAL4  4'h6
`define CLKCFG_SEL_XTAL8  4'h7
`define CLKCFG_SEL_TMR0   4'h8
`define CLKCFG_SEL_TMR1   4'h9
`define CLKCFG_SEL_TMR2   4'hA
`define CLKCFG_SEL_TMR3   4'hB
`define CLKCFG_LAST_BIT   3'h7
`define CLKCFG_RESP_OKAY  2'h0
`define CLKCFG_RESP_SLV   2'h2
`endif

// ---- clkcfg_pkg.sv ----
// types shared by the clock configuration block
package clkcfg_pkg;
  typedef enum logic [1:0] {
    CLKCFG_IDLE  = 2'h0,
    CLKCFG_START = 2'h1,
    CLKCFG_DATA  = 2'h3,
    CLKCFG_STOP  = 2'h2
  } clkcfg_uart_state_t;
endpackage : clkcfg_pkg

// ---- clkcfg_bit_timer.sv ----
// uart bit period timer counting crystal edges
`timescale 1ns/10ps
`include "clkcfg_defines.svh"
module clkcfg_bit_timer
  import clkcfg_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       xtal_rise,
  input  wire logic       restart,
  input  wire logic [7:0] rate,
  output logic            bit_tick,
  output logic            mid_tick
);
  logic [12:0] cnt_reg;
  logic [12:0] cnt_next;
  logic [12:0] period;
  logic        at_end;

  function automatic logic [12:0] bit_period(input logic [7:0] r);
    logic [2:0]  e;
    logic [12:0] m;
    e = r[`CLKCFG_EXP_HI:`CLKCFG_EXP_LO];
    m = {8'h00, r[`CLKCFG_MAN_HI:`CLKCFG_MAN_LO]};
    if (e == 3'h0) begin
      bit_period = m + `CLKCFG_ONE;
    end else begin
      bit_period = (m + `CLKCFG_MAN_OFS) << (e - 3'h1);
    end
  endfunction : bit_period

  assign period   = bit_period(rate);
  assign at_end   = (cnt_reg == period - `CLKCFG_ONE);
  assign bit_tick = xtal_rise & at_end;
  assign mid_tick = xtal_rise & (cnt_reg == (period >> 1));
  assign cnt_next = restart ? 13'h0000 :
                    (xtal_rise ? (at_end ? 13'h0000 : cnt_reg + `CLKCFG_ONE) : cnt_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 13'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule : clkcfg_bit_timer

// ---- clkcfg_top.sv ----
// clock and serial rate configuration with host uart and clock pin mux
`timescale 1ns/10ps
`include "clkcfg_defines.svh"
module clkcfg_top
  import clkcfg_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        xtal_in,
  input  wire logic        pll_clk_in,
  input  wire logic [3:0]  timer_overflow,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic             uart_tx,
  input  wire logic        uart_rx,
  output logic [7:0]       rx_data,
  output logic             rx_valid,
  output logic             rx_frame_error,
  input  wire logic        gpio_out,
  input  wire logic        gpio_oe,
  output logic             clock_output_pin_o,
  output logic             clock_output_pin_oe,
  output logic [7:0]       slow_osc_trim_value,
  output logic             pll_sleep,
  output logic [4:0]       pll_feedback_ratio,
  output logic [7:0]       pll_output_ratio
);
  // software registers
  logic [7:0] rate_reg;
  logic [7:0] trim_reg;
  logic [7:0] pll_reg;
  logic [7:0] pdiv_reg;
  logic [7:0] rate_act_reg;

  // pin synchronisers and level filters
  logic [2:0] xtal_sync_reg;
  logic [2:0] pll_sync_reg;
  logic [2:0] rx_sync_reg;
  logic       xtal_lvl_reg;
  logic       pll_lvl_reg;
  logic       rx_lvl_reg;
  logic [2:0] xtal_div_reg;
  logic [3:0] tmr_tgl_reg;

  function automatic logic filt(input logic [2:0] s, input logic held);
    filt = (s[1] == s[2]) ? s[2] : held;
  endfunction : filt

  wire xtal_lvl_next = filt(xtal_sync_reg, xtal_lvl_reg);
  wire xtal_rise     = xtal_lvl_next & ~xtal_lvl_reg;
  wire rx_lvl_next   = filt(rx_sync_reg, rx_lvl_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xtal_sync_reg <= 3'h0;
      pll_sync_reg  <= 3'h0;
      rx_sync_reg   <= 3'h7;
      xtal_lvl_reg  <= 1'b0;
      pll_lvl_reg   <= 1'b0;
      rx_lvl_reg    <= 1'b1;
    end else begin
      xtal_sync_reg <= {xtal_sync_reg[1:0], xtal_in};
      pll_sync_reg  <= {pll_sync_reg[1:0], pll_clk_in};
      rx_sync_reg   <= {rx_sync_reg[1:0], uart_rx};
      xtal_lvl_reg  <= xtal_lvl_next;
      pll_lvl_reg   <= filt(pll_sync_reg, pll_lvl_reg);
      rx_lvl_reg    <= rx_lvl_next;
    end
  end

  // ---------------- axi4-lite slave ----------------
  logic        aw_full_reg;
  logic        w_full_reg;
  logic [7:0]  aw_idx_reg;
  logic [7:0]  w_byte_reg;
  logic        w_lane_reg;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  logic        wr_hit;

  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire ar_take  = s_axi_arvalid & s_axi_arready;
  wire do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire aw_full_next = (aw_full_reg | aw_take) & ~do_write;
  wire w_full_next  = (w_full_reg | w_take) & ~do_write;
  wire bvalid_next  = do_write | (s_axi_bvalid & ~s_axi_bready);
  wire rvalid_next  = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire [7:0] ar_idx = s_axi_araddr[9:2];
  wire upper_zero   = (s_axi_araddr[11:10] == 2'h0);
  wire aw_ok        = (s_axi_awaddr[11:10] == 2'h0);

  wire wr_rate = do_write & w_lane_reg & (aw_idx_reg == `CLKCFG_IDX_RATE);
  wire wr_trim = do_write & w_lane_reg & (aw_idx_reg == `CLKCFG_IDX_TRIM);
  wire wr_pll  = do_write & w_lane_reg & (aw_idx_reg == `CLKCFG_IDX_PLL);
  wire wr_pdiv = do_write & w_lane_reg & (aw_idx_reg == `CLKCFG_IDX_PDIV);

  always_comb begin
    if (aw_idx_reg == `CLKCFG_IDX_RATE || aw_idx_reg == `CLKCFG_IDX_TRIM) begin
      wr_hit = 1'b1;
    end else if (aw_idx_reg == `CLKCFG_IDX_PLL || aw_idx_reg == `CLKCFG_IDX_PDIV) begin
      wr_hit = 1'b1;
    end else if (aw_idx_reg == `CLKCFG_IDX_STAT || aw_idx_reg == `CLKCFG_IDX_ACT) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // uart state, needed by status readback
  clkcfg_uart_state_t tx_state_reg;
  clkcfg_uart_state_t rx_state_reg;
  wire tx_idle = (tx_state_reg == CLKCFG_IDLE);
  wire rx_idle = (rx_state_reg == CLKCFG_IDLE);
  wire [7:0] stat_byte = {5'h00, (rate_reg != rate_act_reg), ~rx_idle, ~tx_idle};

  always_comb begin
    rd_hit = upper_zero;
    if (ar_idx == `CLKCFG_IDX_RATE) begin
      rd_byte = rate_reg;
    end else if (ar_idx == `CLKCFG_IDX_TRIM) begin
      rd_byte = trim_reg;
    end else if (ar_idx == `CLKCFG_IDX_PLL) begin
      rd_byte = pll_reg;
    end else if (ar_idx == `CLKCFG_IDX_PDIV) begin
      rd_byte = pdiv_reg;
    end else if (ar_idx == `CLKCFG_IDX_STAT) begin
      rd_byte = stat_byte;
    end else if (ar_idx == `CLKCFG_IDX_ACT) begin
      rd_byte = rate_act_reg;
    end else begin
      rd_byte = 8'h00;
      rd_hit  = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      aw_idx_reg    <= 8'h00;
      w_byte_reg    <= 8'h00;
      w_lane_reg    <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CLKCFG_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CLKCFG_RESP_OKAY;
    end else begin
      aw_full_reg   <= aw_full_next;
      w_full_reg    <= w_full_next;
      s_axi_awready <= ~aw_full_next;
      s_axi_wready  <= ~w_full_next;
      s_axi_bvalid  <= bvalid_next;
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid  <= rvalid_next;
      if (aw_take) begin
        // bad addresses land on an undecoded index
        aw_idx_reg <= aw_ok ? s_axi_awaddr[9:2] : 8'hFF;
      end
      if (w_take) begin
        w_byte_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bresp <= wr_hit ? `CLKCFG_RESP_OKAY : `CLKCFG_RESP_SLV;
      end
      if (ar_take) begin
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_hit ? `CLKCFG_RESP_OKAY : `CLKCFG_RESP_SLV;
      end
    end
  end

  // ---------------- configuration registers ----------------
  wire rx_lvl_next_fall = rx_lvl_reg & ~rx_lvl_next;
  // adopt new rate only between characters
  wire rate_load = tx_idle & rx_idle & ~rx_lvl_next_fall;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_reg     <= `CLKCFG_RST_RATE;
      rate_act_reg <= `CLKCFG_RST_RATE;
      trim_reg     <= `CLKCFG_RST_TRIM;
      pll_reg      <= `CLKCFG_RST_PLL;
      pdiv_reg     <= `CLKCFG_RST_PDIV;
    end else begin
      if (wr_rate) begin
        rate_reg <= w_byte_reg;
      end
      if (wr_trim) begin
        trim_reg <= w_byte_reg;
      end
      if (wr_pll) begin
        pll_reg <= w_byte_reg;
      end
      // reserved low values kept as written
      if (wr_pdiv) begin
        pdiv_reg <= w_byte_reg;
      end
      if (rate_load) begin
        rate_act_reg <= rate_reg;
      end
    end
  end

  // ---------------- pll control outputs ----------------
  function automatic logic [4:0] fb_ratio(input logic [1:0] code);
    case (code)
      `CLKCFG_FB_CODE27: fb_ratio = `CLKCFG_FB_27;
      `CLKCFG_FB_CODE28: fb_ratio = `CLKCFG_FB_28;
      default:           fb_ratio = `CLKCFG_FB_23;
    endcase
  endfunction : fb_ratio

  // analog pll takes feedback and output ratios
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slow_osc_trim_value <= `CLKCFG_RST_TRIM;
      pll_sleep           <= 1'b0;
      pll_feedback_ratio  <= `CLKCFG_FB_23;
      pll_output_ratio    <= `CLKCFG_RST_PDIV;
    end else begin
      // oscillator slows as this value rises
      slow_osc_trim_value <= trim_reg;
      pll_sleep           <= pll_reg[`CLKCFG_SLEEP_BIT];
      pll_feedback_ratio  <= fb_ratio(pll_reg[`CLKCFG_FB_HI:`CLKCFG_FB_LO]);
      pll_output_ratio    <= pdiv_reg;
    end
  end

  // ---------------- clock output pin ----------------
  wire [3:0] pin_sel = pll_reg[`CLKCFG_SEL_HI:`CLKCFG_SEL_LO];
  wire       pin_en  = pll_reg[`CLKCFG_EN_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xtal_div_reg <= 3'h0;
      tmr_tgl_reg  <= 4'h0;
    end else begin
      if (xtal_rise) begin
        xtal_div_reg <= xtal_div_reg + 3'h1;
      end
      tmr_tgl_reg <= tmr_tgl_reg ^ timer_overflow;
    end
  end

  logic pin_level;
  always_comb begin
    case (pin_sel)
      `CLKCFG_SEL_GPIO:  pin_level = gpio_out;
      `CLKCFG_SEL_PLL:   pin_level = pll_lvl_reg;
      `CLKCFG_SEL_LOW:   pin_level = 1'b0;
      `CLKCFG_SEL_HIGH:  pin_level = 1'b1;
      `CLKCFG_SEL_XTAL1: pin_level = xtal_lvl_reg;
      `CLKCFG_SEL_XTAL2: pin_level = xtal_div_reg[0];
      `CLKCFG_SEL_XTAL4: pin_level = xtal_div_reg[1];
      `CLKCFG_SEL_XTAL8: pin_level = xtal_div_reg[2];
      `CLKCFG_SEL_TMR0:  pin_level = tmr_tgl_reg[0];
      `CLKCFG_SEL_TMR1:  pin_level = tmr_tgl_reg[1];
      `CLKCFG_SEL_TMR2:  pin_level = tmr_tgl_reg[2];
      `CLKCFG_SEL_TMR3:  pin_level = tmr_tgl_reg[3];
      // reserved codes park the pin low
      default:           pin_level = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_output_pin_o  <= 1'b0;
      clock_output_pin_oe <= 1'b0;
    end else begin
      clock_output_pin_o  <= pin_level;
      // drive only when enabled; io mode follows gpio
      clock_output_pin_oe <= (pin_sel == `CLKCFG_SEL_GPIO) ? gpio_oe : pin_en;
    end
  end

  // ---------------- host uart ----------------
  logic       tx_tick;
  logic       rx_mid;
  logic [7:0] tx_shift_reg;
  logic [2:0] tx_cnt_reg;
  logic [7:0] rx_shift_reg;
  logic [2:0] rx_cnt_reg;

  wire tx_go    = tx_valid & tx_ready;
  wire rx_start = rx_idle & rx_lvl_next_fall;

  // no guard: faster settings stay host responsibility
  clkcfg_bit_timer u_tx_timer (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .xtal_rise (xtal_rise),
    .restart   (tx_go),
    .rate      (rate_act_reg),
    .bit_tick  (tx_tick),
    .mid_tick  ()
  );

  clkcfg_bit_timer u_rx_timer (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .xtal_rise (xtal_rise),
    .restart   (rx_start),
    .rate      (rate_act_reg),
    .bit_tick  (),
    .mid_tick  (rx_mid)
  );

  // start, eight data lsb first, stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_reg <= CLKCFG_IDLE;
      tx_shift_reg <= 8'h00;
      tx_cnt_reg   <= 3'h0;
      uart_tx      <= 1'b1;
      tx_ready     <= 1'b1;
    end else begin
      case (tx_state_reg)
        CLKCFG_IDLE: begin
          if (tx_go) begin
            tx_shift_reg <= tx_data;
            uart_tx      <= 1'b0;
            tx_ready     <= 1'b0;
            tx_state_reg <= CLKCFG_START;
          end
        end
        CLKCFG_START: begin
          if (tx_tick) begin
            uart_tx      <= tx_shift_reg[0];
            tx_cnt_reg   <= 3'h0;
            tx_state_reg <= CLKCFG_DATA;
          end
        end
        CLKCFG_DATA: begin
          if (tx_tick) begin
            tx_cnt_reg <= tx_cnt_reg + 3'h1;
            if (tx_cnt_reg == `CLKCFG_LAST_BIT) begin
              uart_tx      <= 1'b1;
              tx_state_reg <= CLKCFG_STOP;
            end else begin
              uart_tx      <= tx_shift_reg[1];
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            end
          end
        end
        default: begin
          if (tx_tick) begin
            tx_ready     <= 1'b1;
            tx_state_reg <= CLKCFG_IDLE;
          end
        end
      endcase
    end
  end

  // receiver samples at mid bit; a false start returns to idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_reg   <= CLKCFG_IDLE;
      rx_shift_reg   <= 8'h00;
      rx_cnt_reg     <= 3'h0;
      rx_data        <= 8'h00;
      rx_valid       <= 1'b0;
      rx_frame_error <= 1'b0;
    end else begin
      rx_valid       <= 1'b0;
      rx_frame_error <= 1'b0;
      case (rx_state_reg)
        CLKCFG_IDLE: begin
          if (rx_start) begin
            rx_state_reg <= CLKCFG_START;
          end
        end
        CLKCFG_START: begin
          if (rx_mid) begin
            rx_cnt_reg   <= 3'h0;
            rx_state_reg <= rx_lvl_reg ? CLKCFG_IDLE : CLKCFG_DATA;
          end
        end
        CLKCFG_DATA: begin
          if (rx_mid) begin
            rx_shift_reg <= {rx_lvl_reg, rx_shift_reg[7:1]};
            rx_cnt_reg   <= rx_cnt_reg + 3'h1;
            if (rx_cnt_reg == `CLKCFG_LAST_BIT) begin
              rx_state_reg <= CLKCFG_STOP;
            end
          end
        end
        default: begin
          if (rx_mid) begin
            rx_data        <= rx_shift_reg;
            rx_valid       <= rx_lvl_reg;
            rx_frame_error <= ~rx_lvl_reg;
            rx_state_reg   <= CLKCFG_IDLE;
          end
        end
      endcase
    end
  end
endmodule : clkcfg_top

// ---- clkcfg_top_monitor.sv ----
// checker of the clock block ports
`timescale 1ns/10ps
module clkcfg_top_monitor
  import clkcfg_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        uart_tx,
  input wire logic        rx_valid,
  input wire logic        clock_output_pin_o,
  input wire logic        clock_output_pin_oe,
  input wire logic [7:0]  slow_osc_trim_value,
  input wire logic        pll_sleep,
  input wire logic [4:0]  pll_feedback_ratio
);
  logic [11:0] aw_q;
  logic [7:0]  w_q;
  logic [7:0]  pc_m;
  logic [7:0]  tr_m;
  logic        ws_q;
  logic        bv_d;
  logic [4:0]  fb_m;
  logic        quiet;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  assign fb_m = (pc_m[1:0] == 2'h1) ? 5'h1B : (pc_m[1:0] == 2'h2) ? 5'h1C : 5'h17;
  assign quiet = !s_axi_bvalid && !bv_d;
  // mirrors lag a cycle, like the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_m <= 8'h00;
      tr_m <= 8'h00;
      bv_d <= 1'b0;
    end else begin
      bv_d <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) {ws_q, w_q} <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
      if (s_axi_bvalid && !bv_d && ws_q && aw_q == 12'h0F4) pc_m <= w_q;
      if (s_axi_bvalid && !bv_d && ws_q && aw_q == 12'h0F0) tr_m <= w_q;
    end
  end
  property p_tx_start; tx_valid && tx_ready |=> !uart_tx && !tx_ready; endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx start bit missing");
  property p_tx_idle; tx_ready |-> uart_tx; endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("tx line low while idle");
  property p_start_len; $fell(uart_tx) && $fell(tx_ready) |=> !uart_tx [*8]; endproperty
  a_start_len: assert property (p_start_len) else $error("start bit too short");
  property p_pin_low; pc_m[7:3] == 5'h05 |-> clock_output_pin_oe && !clock_output_pin_o;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin not held low");
  property p_pin_high; pc_m[7:3] == 5'h07 |-> clock_output_pin_oe && clock_output_pin_o;
  endproperty
  a_pin_high: assert property (p_pin_high) else $error("pin not held high");
  property p_pin_off; pc_m[7:4] != 4'h0 && !pc_m[3] |-> !clock_output_pin_oe; endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled");
  property p_pin_rsvd; pc_m[7:6] == 2'h3 |-> !clock_output_pin_o; endproperty
  a_pin_rsvd: assert property (p_pin_rsvd) else $error("reserved select not low");
  property p_fb; quiet && $stable(pc_m) |-> pll_feedback_ratio == fb_m; endproperty
  a_fb: assert property (p_fb) else $error("feedback ratio wrong");
  property p_sleep; quiet |-> pll_sleep == pc_m[2]; endproperty
  a_sleep: assert property (p_sleep) else $error("pll sleep wrong");
  property p_trim; quiet |-> slow_osc_trim_value == tr_m; endproperty
  a_trim: assert property (p_trim) else $error("trim output wrong");
  c_tx: cover property (tx_valid && tx_ready);
  c_rx: cover property (rx_valid);
  c_tmr: cover property (pc_m[7:4] == 4'h8 && $changed(clock_output_pin_o));
endmodule : clkcfg_top_monitor
bind clkcfg_top clkcfg_top_monitor clkcfg_top_monitor_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .uart_tx(uart_tx), .rx_valid(rx_valid),
  .clock_output_pin_o(clock_output_pin_o), .clock_output_pin_oe(clock_output_pin_oe),
  .slow_osc_trim_value(slow_osc_trim_value), .pll_sleep(pll_sleep),
  .pll_feedback_ratio(pll_feedback_ratio));

// ---- clkcfg_host_model.sv ----
// host at the far end of the serial link
`timescale 1ns/10ps
module clkcfg_host_model (
  input wire logic        aclk,
  input wire logic        uart_tx,
  input wire logic [15:0] bit_cyc,
  output logic            uart_rx,
  output logic [7:0]      got_byte,
  output logic            got_ok,
  output int              got_cnt
);
  initial uart_rx = 1'b1;
  always begin : rcv
    logic [7:0] b;
    @(negedge uart_tx);
    repeat (bit_cyc / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge aclk);
      b[i] = uart_tx;
    end
    repeat (bit_cyc) @(posedge aclk);
    got_ok = uart_tx;
    got_byte = b;
    got_cnt++;
  end
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      uart_rx <= f[i];
      repeat (bit_cyc) @(posedge aclk);
    end
  endtask : send
endmodule : clkcfg_host_model

// ---- clkcfg_top_tb_top.sv ----
// bench for the clock configuration block
`timescale 1ns/10ps
module clkcfg_top_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, xtal_in, pll_clk_in;
  logic tx_valid, gpio_out, gpio_oe, awready, wready, bvalid, arready, rvalid, tx_ready;
  logic uart_tx, uart_rx, rx_valid, rx_ferr, pin_o, pin_oe, sleep, got_ok;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rsp;
  logic [3:0]  wstrb, tmr;
  logic [7:0]  tx_data, rx_data, trim, ratio, got_byte;
  logic [4:0]  fb;
  logic [15:0] bit_len;
  int          err_count, n_compared, cyc, got_cnt, k, n;
  clkcfg_top clkcfg_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .xtal_in(xtal_in), .pll_clk_in(pll_clk_in), .timer_overflow(tmr),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .uart_tx(uart_tx),
    .uart_rx(uart_rx), .rx_data(rx_data), .rx_valid(rx_valid), .rx_frame_error(rx_ferr),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .clock_output_pin_o(pin_o),
    .clock_output_pin_oe(pin_oe), .slow_osc_trim_value(trim), .pll_sleep(sleep),
    .pll_feedback_ratio(fb), .pll_output_ratio(ratio));
  clkcfg_host_model clkcfg_host_model_inst (.aclk(aclk), .uart_tx(uart_tx), .bit_cyc(bit_len),
    .uart_rx(uart_rx), .got_byte(got_byte), .got_ok(got_ok), .got_cnt(got_cnt));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // crystal 8, pll 10 cycles; watchdog
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    xtal_in <= cyc[2];
    pll_clk_in <= (cyc % 10) < 5;
    if (cyc == 40000) begin
      err_count++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!((awready || !awvalid) && (wready || !wvalid)));
    do @(posedge aclk); while (!bvalid);
    r = bresp;
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : axi_rd
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    axi_rd(a, rd, rsp);
    chk("rdata", {24'h000000, e}, rd);
    chk("rresp", 32'h0, 32'(rsp));
  endtask : rchk
  task automatic pin(input logic [3:0] s, input logic en);
    axi_wr(12'h0F4, {s, en, 3'h0}, rsp);
    repeat (3) @(posedge aclk);
  endtask : pin
  task automatic edges(input int c, output int m);
    logic p;
    m = 0;
    p = pin_o;
    repeat (c) begin
      @(posedge aclk);
      if (pin_o && !p) m++;
      p = pin_o;
    end
  endtask : edges
  task automatic pulse(input int t);
    tmr <= 4'h1 << t;
    @(posedge aclk);
    tmr <= 4'h0;
    repeat (4) @(posedge aclk);
  endtask : pulse
  task automatic xmit(input logic [7:0] b);
    tx_data <= b;
    tx_valid <= 1'b1;
    do @(posedge aclk); while (!tx_ready);
    tx_valid <= 1'b0;
  endtask : xmit
  task automatic wait_host(input int c);
    while (got_cnt < c) @(posedge aclk);
  endtask : wait_host
  task automatic wait_pulse(input logic f);
    do @(posedge aclk); while (!(f ? rx_ferr : rx_valid));
  endtask : wait_pulse
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  initial begin
    {aresetn, awvalid, wvalid, arvalid, tx_valid} = '0;
    {awaddr, araddr, wdata, tmr, tx_data} = '0;
    {gpio_out, gpio_oe, bready, rready, wstrb, bit_len} = {4'hF, 4'hF, 16'd176};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(12'h0EC, 8'h7A);
    rchk(12'h0F8, 8'h08);
    chk("fb", 32'd23, 32'(fb));
    axi_rd(12'h100, rd, rsp);
    chk("unmapped", 32'h2, {rd[29:0], rsp});
    axi_wr(12'h0F0, 8'hA5, rsp);
    chk("bresp", 32'h0, 32'(rsp));
    rchk(12'h0F0, 8'hA5);
    chk("trim", 32'hA5, 32'(trim));
    axi_wr(12'h0F8, 8'hC8, rsp);
    @(posedge aclk);
    chk("ratio", 32'hC8, 32'(ratio));
    for (k = 0; k < 4; k++) begin
      axi_wr(12'h0F4, {5'h00, k[0], k[1:0]}, rsp);
      rchk(12'h0F4, {5'h00, k[0], k[1:0]});
      chk("fb", (k == 1) ? 32'd27 : (k == 2) ? 32'd28 : 32'd23, 32'(fb));
      chk("sleep", 32'(k[0]), 32'(sleep));
    end
    pin(4'h2, 1'b1);
    chk("low", 32'h2, 32'({pin_oe, pin_o}));
    pin(4'h3, 1'b1);
    chk("high", 32'h3, 32'({pin_oe, pin_o}));
    pin(4'hC, 1'b1);
    chk("rsvd", 32'h2, 32'({pin_oe, pin_o}));
    pin(4'h3, 1'b0);
    chk("off", 32'h0, 32'(pin_oe));
    pin(4'h0, 1'b0);
    chk("io", 32'h3, 32'({pin_oe, pin_o}));
    pin(4'h1, 1'b1);
    edges(200, n);
    chk("pll", 32'h1, 32'(n >= 19 && n <= 21));
    // sampled crystal, one edge slack
    for (k = 4; k < 8; k++) begin
      pin(k[3:0], 1'b1);
      edges(256, n);
      n -= 32 >> (k - 4);
      chk("xdiv", 32'h1, 32'(n >= -1 && n <= 1));
    end
    for (k = 0; k < 4; k++) begin
      pin(4'h8 + k[3:0], 1'b1);
      rd[0] = pin_o;
      pulse((k + 1) % 4);
      chk("other tmr", 32'(rd[0]), 32'(pin_o));
      pulse(k);
      chk("tmr", 32'(!rd[0]), 32'(pin_o));
    end
    axi_wr(12'h0EC, 8'h15, rsp);
    xmit(8'h5A);
    wait_host(1);
    chk("tx", 32'h15A, 32'({got_ok, got_byte}));
    bit_len = 16'd264;
    axi_wr(12'h0EC, 8'h20, rsp);
    xmit(8'hA5);
    repeat (50) @(posedge aclk);
    axi_wr(12'h0EC, 8'h40, rsp);
    axi_rd(12'h110, rd, rsp);
    chk("pending", 32'h1, 32'(rd[2]));
    wait_host(2);
    chk("tx", 32'h1A5, 32'({got_ok, got_byte}));
    bit_len = 16'd528;
    xmit(8'h3C);
    wait_host(3);
    chk("tx", 32'h13C, 32'({got_ok, got_byte}));
    rchk(12'h114, 8'h40);
    fork
      clkcfg_host_model_inst.send(8'hC3, 1'b1);
      wait_pulse(1'b0);
    join
    chk("rx", 32'hC3, 32'(rx_data));
    fork
      clkcfg_host_model_inst.send(8'h81, 1'b0);
      wait_pulse(1'b1);
    join
    conclude();
  end
endmodule : clkcfg_top_tb_top
